// ===== spi_port_pkg.sv
package spi_port_pkg;

  // ***********************************************************
  // Register map and field layout
  // ***********************************************************
  localparam logic [1:0] ADDR_CTRL = 2'h0;
  localparam logic [1:0] ADDR_STAT = 2'h1;
  localparam logic [1:0] ADDR_DATA = 2'h2;

  localparam int STAT_TCF_BIT = 7;
  localparam int STAT_WRITE_COLLISION_FLAG_BIT = 6;
  localparam int STAT_DBL_BIT = 0;

  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [4:0] STAT_RES_VAL = 5'h00;

  // ***********************************************************
  // Serial clock divisors, in system clocks per serial clock
  // ***********************************************************
  localparam int DIV_N0 = 4;
  localparam int DIV_N1 = 16;
  localparam int DIV_N2 = 64;
  localparam int DIV_N3 = 128;
  localparam int DIV_D0 = 2;
  localparam int DIV_D1 = 8;
  localparam int DIV_D2 = 32;
  localparam int DIV_D3 = 64;

  // Sixteen clock edges make the eight bits of one transfer.
  localparam logic [3:0] LAST_EDGE = 4'hf;

  typedef struct packed {
    logic int_en;
    logic enable;
    logic lsb_first;
    logic master;
    logic clock_polarity_bit;
    logic clock_phase_bit;
    logic [1:0] rate;
  } ctrl_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHIFT = 2'b01,
    ST_FINISH = 2'b11
  } xfer_state_t;

  // Half a serial clock period, minus one, in system clocks.
  function automatic logic [6:0] half_load(input logic [1:0] rate,
                                           input logic dbl);
    int div;
    div = DIV_N0;
    unique case ({dbl, rate})
      3'b000: div = DIV_N0;
      3'b001: div = DIV_N1;
      3'b010: div = DIV_N2;
      3'b011: div = DIV_N3;
      3'b100: div = DIV_D0;
      3'b101: div = DIV_D1;
      3'b110: div = DIV_D2;
      3'b111: div = DIV_D3;
    endcase
    return 7'(div / 2 - 1);
  endfunction : half_load

  function automatic logic first_bit(input logic [7:0] v,
                                     input logic lsb);
    return lsb ? v[0] : v[7];
  endfunction : first_bit

endpackage : spi_port_pkg

// ===== spi_rate_gen.sv
`timescale 1ns/10ps
module spi_rate_gen #(
  parameter int CNT_W = 7
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [CNT_W-1:0] half,
  output logic tick
);

  logic [CNT_W-1:0] cnt_q;

  initial begin
    if (CNT_W < 1) begin
      $error("spi_rate_gen: CNT_W must be at least 1");
    end
  end

  // The counter is held at its load value while stopped, so the first
  // edge of a transfer comes one full half period after the start.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (!run || cnt_q == '0) begin
      cnt_q <= half;
    end else begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign tick = run && (cnt_q == '0);

endmodule : spi_rate_gen

// ===== spi_shifter.sv
`timescale 1ns/10ps
module spi_shifter #(
  parameter int WIDTH = 8
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_val,
  input wire logic shift,
  input wire logic ser_in,
  input wire logic lsb_first,
  output logic [WIDTH-1:0] q
);

  initial begin
    if (WIDTH < 2) begin
      $error("spi_shifter: WIDTH must be at least 2");
    end
  end

  // One register serves both directions: each shift pushes the outgoing
  // bit away and takes the incoming bit in at the opposite end.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else if (load) begin
      q <= load_val;
    end else if (shift) begin
      q <= lsb_first ? {ser_in, q[WIDTH-1:1]} : {q[WIDTH-2:0], ser_in};
    end
  end

endmodule : spi_shifter

// ===== spi_port.sv
`timescale 1ns/10ps
module spi_port
  import spi_port_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  input wire logic global_int_en,
  input wire logic int_ack,
  output logic irq,
  input wire logic ss_is_output,
  input wire logic ss_n_in,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe
);

  // ***********************************************************
  // Register state and decode
  // ***********************************************************
  ctrl_t ctrl_q;
  xfer_state_t state_q;
  logic dbl_q;
  logic tcf_q;
  logic write_collision_flag_q;
  logic seen_tcf_q;
  logic seen_write_collision_flag_q;
  logic [7:0] rx_buf_q;
  logic [7:0] tx_hold_q;
  logic [7:0] rdata_q;
  logic [3:0] edge_cnt_q;
  logic sck_q;
  logic sck_prev_q;
  logic out_q;
  logic [7:0] shift_q;
  logic [6:0] half_w;
  logic tick;
  logic data_wr;
  logic data_rd;
  logic status_rd;
  logic data_acc;
  logic busy;
  logic start;
  logic mode_fault;
  logic abort;
  logic slave_sel;
  logic edge_ev;
  logic sample_ev;
  logic setup_ev;
  logic last_edge;
  logic ser_in;
  logic shift_load;
  logic [7:0] shift_val;
  logic run;

  assign data_wr = wr_stb && addr == ADDR_DATA;
  assign data_rd = rd_stb && addr == ADDR_DATA;
  assign status_rd = rd_stb && addr == ADDR_STAT;
  assign data_acc = data_wr || data_rd;
  assign busy = state_q != ST_IDLE;
  assign start = data_wr && ctrl_q.enable && !busy;
  assign mode_fault = ctrl_q.enable && ctrl_q.master && !ss_is_output &&
                      !ss_n_in;
  assign abort = !ctrl_q.enable || mode_fault ||
                 (!ctrl_q.master && ss_n_in);
  assign slave_sel = ctrl_q.enable && !ctrl_q.master && !ss_n_in;

  // ***********************************************************
  // Serial clock and edge timing
  // ***********************************************************
  // slave ignores rate
  assign run = ctrl_q.enable && ctrl_q.master && state_q == ST_SHIFT;
  assign half_w = half_load(ctrl_q.rate, dbl_q);

  spi_rate_gen #(
    .CNT_W(7)
  ) u_rate (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .run(run),
    .half(half_w),
    .tick(tick)
  );

  // The slave sees clock edges as changes of the sampled pin, which is
  // why an external master must stay at or below a quarter of core_clk.
  assign edge_ev = ctrl_q.master ? run && tick
                 : slave_sel && (sck_in != sck_prev_q);
  // mode edge choice
  // Phase clear samples on the even edges, which are the leading ones.
  assign sample_ev = edge_ev && (edge_cnt_q[0] == ctrl_q.clock_phase_bit);
  assign setup_ev = edge_ev && !sample_ev;
  assign last_edge = edge_ev && edge_cnt_q == LAST_EDGE;
  assign ser_in = ctrl_q.master ? miso_in : mosi_in;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_prev_q <= 1'b0;
    end else begin
      sck_prev_q <= sck_in;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_q <= 1'b0;
    end else if (ctrl_q.master && state_q == ST_SHIFT && !abort) begin
      sck_q <= tick ? !sck_q : sck_q;
    end else begin
      sck_q <= ctrl_q.clock_polarity_bit;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      edge_cnt_q <= '0;
    end else if (abort) begin
      edge_cnt_q <= '0;
    end else if (edge_ev) begin
      edge_cnt_q <= edge_cnt_q + 4'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
    end else if (abort) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if ((start && ctrl_q.master) || edge_ev) begin
            state_q <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (last_edge) begin
            state_q <= ST_FINISH;
          end
        end
        ST_FINISH: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ***********************************************************
  // Shift register and pin drive
  // ***********************************************************
  // A torn slave transfer restores the last written byte, so the next
  // select sends it again instead of leftover half-shifted bits.
  assign shift_load = start || (abort && busy);
  assign shift_val = start ? wdata : tx_hold_q;

  spi_shifter #(
    .WIDTH(8)
  ) u_shift (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .load(shift_load),
    .load_val(shift_val),
    .shift(sample_ev && !abort),
    .ser_in(ser_in),
    .lsb_first(ctrl_q.lsb_first),
    .q(shift_q)
  );

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_hold_q <= DATA_RST;
    end else if (start) begin
      tx_hold_q <= wdata;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= 1'b0;
    end else if (shift_load) begin
      out_q <= first_bit(shift_val, ctrl_q.lsb_first);
    end else if (setup_ev) begin
      out_q <= first_bit(shift_q, ctrl_q.lsb_first);
    end
  end

  assign sck_out = sck_q;
  assign sck_oe = ctrl_q.enable && ctrl_q.master;
  assign mosi_out = out_q;
  assign mosi_oe = ctrl_q.enable && ctrl_q.master;
  assign miso_out = out_q;
  assign miso_oe = slave_sel;

  // ***********************************************************
  // Registers
  // ***********************************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= ctrl_t'(CTRL_RST);
    end else if (mode_fault) begin
      ctrl_q.master <= 1'b0;
    end else if (wr_stb && addr == ADDR_CTRL) begin
      ctrl_q <= ctrl_t'(wdata);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dbl_q <= 1'b0;
    end else if (wr_stb && addr == ADDR_STAT) begin
      dbl_q <= wdata[STAT_DBL_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_buf_q <= DATA_RST;
    end else if (state_q == ST_FINISH) begin
      rx_buf_q <= shift_q;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      seen_tcf_q <= 1'b0;
      seen_write_collision_flag_q <= 1'b0;
    end else if (status_rd) begin
      seen_tcf_q <= tcf_q;
      seen_write_collision_flag_q <= write_collision_flag_q;
    end else if (data_acc) begin
      seen_tcf_q <= 1'b0;
      seen_write_collision_flag_q <= 1'b0;
    end
  end

  // A new completion in the clearing cycle wins over the clear.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tcf_q <= 1'b0;
    end else if (state_q == ST_FINISH || mode_fault) begin
      tcf_q <= 1'b1;
    end else if (int_ack || (data_acc && (seen_tcf_q || seen_write_collision_flag_q))) begin
      tcf_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      write_collision_flag_q <= 1'b0;
    end else if (data_wr && busy) begin
      write_collision_flag_q <= 1'b1;
    end else if (data_acc && seen_write_collision_flag_q) begin
      write_collision_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else if (rd_stb) begin
      unique case (addr)
        ADDR_CTRL: rdata_q <= ctrl_q;
        ADDR_STAT: rdata_q <= {tcf_q, write_collision_flag_q, STAT_RES_VAL, dbl_q};
        ADDR_DATA: rdata_q <= rx_buf_q;
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign rdata = rdata_q;
  assign irq = tcf_q && ctrl_q.int_en && global_int_en;

  // ***********************************************************
  // Checks
  // ***********************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  logic [7:0] gap_q;
  logic gap_ok_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_q <= 8'h00;
      gap_ok_q <= 1'b0;
    end else if (!run) begin
      gap_q <= 8'h00;
      gap_ok_q <= 1'b0;
    end else if (tick) begin
      gap_q <= 8'h00;
      gap_ok_q <= 1'b1;
    end else begin
      gap_q <= gap_q + 8'h01;
    end
  end

  property p_rate_norm;
    run && tick && gap_ok_q && !dbl_q && $stable(ctrl_q.rate) |->
      gap_q == 8'(half_load(ctrl_q.rate, 1'b0));
  endproperty
  a_rate_norm: assert property (p_rate_norm) else $error("rate");
  property p_rate_dbl;
    run && tick && gap_ok_q && dbl_q && ctrl_q.rate == 2'b01 |->
      gap_q == 8'h03;
  endproperty
  a_rate_dbl: assert property (p_rate_dbl) else $error("rate x2");
  property p_slave_quiet;
    !ctrl_q.master |=> sck_q == $past(ctrl_q.clock_polarity_bit) && !tick;
  endproperty
  a_slave_quiet: assert property (p_slave_quiet) else $error("tick");
  property p_fast;
    run && dbl_q && ctrl_q.rate == 2'b00 && !abort ##1 run |->
      sck_q != $past(sck_q);
  endproperty
  a_fast: assert property (p_fast) else $error("fast sck");
  property p_done_flag;
    state_q == ST_FINISH |=> tcf_q && rx_buf_q == $past(shift_q);
  endproperty
  a_done_flag: assert property (p_done_flag) else $error("done");
  property p_irq;
    irq |-> tcf_q && ctrl_q.int_en;
  endproperty
  a_irq: assert property (p_irq) else $error("irq");
  property p_fault;
    mode_fault |=> tcf_q && !ctrl_q.master && !sck_oe;
  endproperty
  a_fault: assert property (p_fault) else $error("mode fault");
  property p_vec_clr;
    int_ack && state_q != ST_FINISH && !mode_fault |=> !tcf_q;
  endproperty
  a_vec_clr: assert property (p_vec_clr) else $error("vector");
  property p_collide;
    data_wr && busy |=> write_collision_flag_q ##1 1'b1;
  endproperty
  a_collide: assert property (p_collide) else $error("write_collision_flag");
  property p_res;
    status_rd |=> rdata[5:1] == 5'h00 && rdata[7] == $past(tcf_q);
  endproperty
  a_res: assert property (p_res) else $error("status");
  property p_rd;
    data_rd |=> rdata == $past(rx_buf_q);
  endproperty
  a_rd: assert property (p_rd) else $error("data read");
  property p_drop;
    ctrl_q.enable && !ctrl_q.master && ss_n_in |=>
      edge_cnt_q == 4'h0 && state_q == ST_IDLE;
  endproperty
  a_drop: assert property (p_drop) else $error("ss drop");

  c_master: cover property (ctrl_q.master && state_q == ST_FINISH);
  c_slave: cover property (!ctrl_q.master && state_q == ST_FINISH);
  c_write_collision_flag: cover property ($rose(write_collision_flag_q));
  c_fault: cover property (mode_fault);

endmodule : spi_port

// ===== spi_peer_model.sv
`timescale 1ns/10ps
module spi_peer_model (
  input wire logic sck,
  input wire logic mosi,
  input wire logic sel_n,
  input wire logic clock_polarity_bit,
  input wire logic clock_phase_bit,
  input wire logic lsb_first,
  input wire logic [7:0] tx_byte,
  output logic miso,
  output logic [7:0] rx_byte
);
  int shown = 0;
  logic lead;

  initial begin
    miso = 1'b0;
    rx_byte = 8'h00;
  end

  // Outside its bit window the line is not trusted, so it flips.
  task automatic drive_bit();
    if (shown >= 0 && shown < 8) begin
      miso = lsb_first ? tx_byte[shown] : tx_byte[7 - shown];
    end else begin
      miso = ~miso;
    end
  endtask : drive_bit

  always @(negedge sel_n) begin
    rx_byte = 8'h00;
    shown = clock_phase_bit ? -1 : 0;
    drive_bit();
  end

  always @(posedge sel_n) begin
    miso = ~miso;
  end

  always @(sck) begin
    if (!sel_n) begin
      #1;
      lead = (sck != clock_polarity_bit);
      if (lead ^ clock_phase_bit) begin
        rx_byte = lsb_first ? {mosi, rx_byte[7:1]} : {rx_byte[6:0], mosi};
      end else begin
        shown++;
        drive_bit();
      end
    end
  end
endmodule : spi_peer_model

// ===== spi_port_bench.sv
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin \
  bad_count++; $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module spi_port_bench;
  import spi_port_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [7:0] rdata;
  logic global_int_en = 1'b0;
  logic int_ack = 1'b0;
  logic irq;
  logic ss_is_output = 1'b1;
  logic ss_n_in = 1'b1;
  logic sck_drv = 1'b0;
  logic bit_drv = 1'b0;
  logic drv_act = 1'b0;
  logic junk = 1'b0;
  logic sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, peer_miso;
  wire logic sck_w, mosi_w, miso_w;
  logic peer_sel_n = 1'b1;
  logic p_clock_polarity_bit = 1'b0;
  logic p_clock_phase_bit = 1'b0;
  logic p_lsb = 1'b0;
  logic [7:0] peer_tx = 8'h00;
  logic [7:0] peer_rx;
  logic sck_prev = 1'b0;
  logic [31:0] lfsr = 32'hc5ca335a;
  int bad_count = 0;
  int checks = 0;
  int cycles = 0;
  int edges = 0;
  int gap = 0;
  int gmin = 0;
  int gmax = 0;

  // A pin is the driver's value while enabled, else the far party's, but mosi takes junk while drv_act is low.
  assign sck_w = sck_oe ? sck_out : sck_drv;
  assign mosi_w = mosi_oe ? mosi_out : (drv_act ? bit_drv : junk);
  assign miso_w = miso_oe ? miso_out : peer_miso;

  spi_port dut (
    .core_clk(core_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .global_int_en(global_int_en), .int_ack(int_ack), .irq(irq),
    .ss_is_output(ss_is_output), .ss_n_in(ss_n_in), .sck_in(sck_w),
    .sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(mosi_w),
    .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_w),
    .miso_out(miso_out), .miso_oe(miso_oe)
  );

  spi_peer_model peer (
    .sck(sck_w), .mosi(mosi_w), .sel_n(peer_sel_n), .clock_polarity_bit(p_clock_polarity_bit),
    .clock_phase_bit(p_clock_phase_bit), .lsb_first(p_lsb), .tx_byte(peer_tx),
    .miso(peer_miso), .rx_byte(peer_rx)
  );

  always #50 core_clk = ~core_clk;

  // **********************************************************
  // Serial clock edge and half period watch, hang guard
  // **********************************************************
  // Sampled on the falling edge, away from the edge that moves the pin.
  always @(negedge core_clk) begin
    cycles++;
    junk <= ~junk;
    if (sck_out !== sck_prev) begin
      edges++;
      if (edges > 1) begin
        if (gap < gmin) gmin = gap;
        if (gap > gmax) gmax = gap;
      end
      gap = 1;
    end else begin
      gap++;
    end
    sck_prev = sck_out;
    if (cycles == 40000) begin
      bad_count++;
      finish_test();
    end
  end

  function automatic logic [31:0] next_rand();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : next_rand

  function automatic int expected_half(input logic dbl, input logic [1:0] r);
    int divs [8] = '{4, 16, 64, 128, 2, 8, 32, 64};
    return divs[{dbl, r}] / 2;
  endfunction : expected_half

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge core_clk);
    wr_stb <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge core_clk);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask : reg_rd

  task automatic poll_done(output logic [7:0] s);
    for (int i = 0; i < 1500; i++) begin
      reg_rd(ADDR_STAT, s);
      if (s[7]) break;
    end
  endtask : poll_done

  // **********************************************************
  // Master transfers against the peer
  // **********************************************************
  task automatic master_xfer(input logic [2:0] k);
    logic [31:0] r;
    logic [7:0] tx, s, d;
    logic ie, lsb, coll;
    logic [1:0] mode;
    r = next_rand();
    mode = k[1:0] ^ {k[2], 1'b0};
    lsb = r[0];
    ie = r[1] | (k == 3'h3);
    coll = (k == 3'h5);
    tx = (k == 3'h0) ? 8'h81 : r[15:8];
    reg_wr(ADDR_CTRL, {ie, 1'b1, lsb, 1'b1, mode, k[1:0]});
    reg_wr(ADDR_STAT, {7'h00, k[2]});
    global_int_en <= r[2] | (k == 3'h3);
    peer_tx <= (k == 3'h0) ? 8'h7e : r[23:16];
    p_clock_polarity_bit <= mode[1];
    p_clock_phase_bit <= mode[0];
    p_lsb <= lsb;
    repeat (2) @(posedge core_clk);
    `CHK("idle sck", mode[1], sck_out)
    `CHK("irq idle", 1'b0, irq)
    peer_sel_n <= 1'b0;
    edges = 0;
    gmin = 1000;
    gmax = 0;
    reg_wr(ADDR_DATA, tx);
    if (coll) begin
      repeat (3) @(posedge core_clk);
      reg_wr(ADDR_DATA, ~tx);
    end
    poll_done(s);
    `CHK("status", {1'b1, coll, 5'h00, k[2]}, s)
    `CHK("irq", ie & global_int_en, irq)
    `CHK("edges", 16, edges)
    `CHK("half min", expected_half(k[2], k[1:0]), gmin)
    `CHK("half max", expected_half(k[2], k[1:0]), gmax)
    `CHK("peer rx", tx, peer_rx)
    if (k == 3'h2) begin
      @(posedge core_clk);
      int_ack <= 1'b1;
      @(posedge core_clk);
      int_ack <= 1'b0;
      reg_rd(ADDR_STAT, s);
      `CHK("ack clear", 1'b0, s[7])
    end
    reg_rd(ADDR_DATA, d);
    `CHK("rx data", peer_tx, d)
    reg_rd(ADDR_STAT, s);
    `CHK("flags", 2'b00, s[7:6])
    peer_sel_n <= 1'b1;
  endtask : master_xfer

  // Slave frames run at /9, inside the quarter-clock ceiling.
  // external clock limit
  task automatic slave_bits(input logic [7:0] v, input int n,
                            output logic [7:0] got);
    got = 8'h00;
    @(posedge core_clk);
    ss_n_in <= 1'b0;
    drv_act <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      bit_drv <= v[7 - i];
      sck_drv <= 1'b0;
      repeat (3) @(posedge core_clk);
      #1 got = {got[6:0], miso_w};
      @(posedge core_clk);
      sck_drv <= 1'b1;
      repeat (4) @(posedge core_clk);
    end
    sck_drv <= 1'b0;
    @(posedge core_clk);
    ss_n_in <= 1'b1;
    drv_act <= 1'b0;
  endtask : slave_bits

  initial begin
    logic [7:0] v, s, stx, srx;
    logic [31:0] r;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    reg_rd(ADDR_CTRL, v);
    `CHK("ctrl reset", CTRL_RST, v)
    reg_wr(2'h3, 8'hff);
    reg_rd(2'h3, v);
    `CHK("unmapped", 8'h00, v)
    reg_rd(ADDR_STAT, v);
    `CHK("stat reset", 8'h00, v)
    for (int k = 0; k < 8; k++) master_xfer(3'(k));
    reg_wr(ADDR_CTRL, 8'h50);
    ss_is_output <= 1'b0;
    ss_n_in <= 1'b0;
    repeat (3) @(posedge core_clk);
    ss_n_in <= 1'b1;
    reg_rd(ADDR_CTRL, v);
    `CHK("mode fault ctrl", 8'h40, v)
    `CHK("mode fault sck oe", 1'b0, sck_oe)
    `CHK("mode fault mosi oe", 1'b0, mosi_oe)
    reg_rd(ADDR_STAT, s);
    `CHK("mode fault tcf", 1'b1, s[7])
    reg_rd(ADDR_DATA, v);
    r = next_rand();
    stx = r[7:0];
    srx = r[15:8];
    reg_wr(ADDR_CTRL, {6'h10, r[17:16]});
    reg_wr(ADDR_DATA, stx);
    slave_bits(~srx, 3, v);
    reg_rd(ADDR_STAT, s);
    `CHK("partial tcf", 1'b0, s[7])
    slave_bits(srx, 8, v);
    `CHK("slave tx", stx, v)
    poll_done(s);
    `CHK("slave tcf", 1'b1, s[7])
    reg_rd(ADDR_DATA, v);
    `CHK("slave rx", srx, v)
    finish_test();
  end
endmodule : spi_port_bench
